// File: src/afr_event_sync.sv
// Capture stage that delays the converter result strobes and data by one register stage, with no edge detection.
`timescale 1ns/1ps
module afr_event_sync
    import afr_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire afr_conv_t conv_i,
    output afr_conv_t      conv_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            conv_o <= '0;
        end else begin
            conv_o <= conv_i;
        end
    end
endmodule

// File: src/afr_pkg.sv
// Package with register map, field positions and bus types of the flag and result slice.
package afr_pkg;

    localparam logic [11:0] OFS_FLAGS      = 12'h018;
    localparam logic [11:0] OFS_FLAG_SET   = 12'h01C;
    localparam logic [11:0] OFS_FLAG_CLEAR = 12'h020;
    localparam logic [11:0] OFS_SINGLE_RES = 12'h024;
    localparam logic [11:0] OFS_SCAN_RES   = 12'h028;
    localparam logic [11:0] OFS_IRQ_MASK   = 12'h040;
    localparam logic [11:0] OFS_STATE      = 12'h044;

    localparam int BIT_SINGLE_DONE = 0;
    localparam int BIT_SCAN_DONE   = 1;
    localparam int BIT_SINGLE_OVF  = 8;
    localparam int BIT_SCAN_OVF    = 9;
    localparam int BIT_SINGLE_DV   = 0;
    localparam int BIT_SCAN_DV     = 1;

    localparam logic [31:0] FLAG_MASK   = 32'h0000_0303;
    localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD  = 3'h2;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } afr_ahb_req_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } afr_ahb_rsp_t;

    typedef struct packed {
        logic        single_valid;
        logic [31:0] single_data;
        logic        single_ovf;
        logic        scan_valid;
        logic [31:0] scan_data;
        logic        scan_ovf;
    } afr_conv_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_READ
    } afr_phase_t;

endpackage

// File: src/afr_regs.sv
// Interrupt flag, flag set and clear, and result data registers on an AHB-Lite slave.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module afr_regs
    import afr_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire afr_ahb_req_t      ahb_i,
    output afr_ahb_rsp_t           ahb_o,
    input  wire afr_conv_t         conv_i,
    output logic                   irq_o,
    output logic                   single_valid_o,
    output logic                   scan_valid_o
);
    typedef struct packed {
        afr_phase_t  phase;
        logic [11:0] addr;
        logic [31:0] flags;
        logic [31:0] mask;
        logic        single_dv;
        logic        scan_dv;
        logic        irq;
        logic        rdmux;
        logic [31:0] rdata;
        logic        rd_single;
        logic        rd_scan;
    } afr_state_t;

    afr_state_t  st;
    afr_state_t  next_st;
    afr_conv_t   ev;
    logic [31:0] res_data;
    logic        res_wr;
    logic        res_wr_addr;
    logic [31:0] res_wr_data;
    logic        res_rd_addr;

    function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    afr_event_sync u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .conv_i (conv_i),
        .conv_o (ev)
    );

    // Scan results win the write port on a tie; the single result of that cycle is then not stored.
    assign res_wr      = ev.single_valid | ev.scan_valid;
    assign res_wr_addr = ev.scan_valid;
    assign res_wr_data = ev.scan_valid ? ev.scan_data : ev.single_data;
    assign res_rd_addr = is_reg(ahb_i.haddr[11:0], OFS_SCAN_RES);

    afr_result_store #(.WIDTH(DATA_W)) u_store (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_en_i   (res_wr),
        .wr_addr_i (res_wr_addr),
        .wr_data_i (res_wr_data),
        .rd_addr_i (res_rd_addr),
        .rd_data_o (res_data)
    );

    logic take;
    assign take = ahb_i.hsel && ahb_i.hready && ahb_i.htrans == HTRANS_NSEQ;

    always_comb begin
        logic [31:0] set_bits;
        logic [31:0] clr_bits;
        logic [31:0] hw_bits;
        set_bits = '0;
        clr_bits = '0;
        hw_bits  = '0;
        next_st  = st;
        next_st.rd_single = 1'b0;
        next_st.rd_scan   = 1'b0;
        next_st.rdmux     = 1'b0;

        case (st.phase)
            PH_WRITE: begin
                if (is_reg(st.addr, OFS_FLAG_SET)) begin
                    set_bits = ahb_i.hwdata & FLAG_MASK;
                end
                if (is_reg(st.addr, OFS_FLAG_CLEAR)) begin
                    clr_bits = ahb_i.hwdata & FLAG_MASK;
                end
                if (is_reg(st.addr, OFS_IRQ_MASK)) begin
                    next_st.mask = ahb_i.hwdata & FLAG_MASK;
                end
            end
            PH_READ: begin
            end
            PH_IDLE: begin
            end
            default: begin
            end
        endcase

        hw_bits[BIT_SINGLE_DONE] = ev.single_valid;
        hw_bits[BIT_SCAN_DONE]   = ev.scan_valid;
        hw_bits[BIT_SINGLE_OVF]  = ev.single_ovf;
        hw_bits[BIT_SCAN_OVF]    = ev.scan_ovf;
        // Hardware events and set writes beat a clear in the same cycle.
        next_st.flags = ((st.flags & ~clr_bits) | set_bits | hw_bits) & FLAG_MASK;

        // A read clears valid unless a new result lands in that same cycle.
        if (st.rd_single) begin
            next_st.single_dv = 1'b0;
        end
        if (st.rd_scan) begin
            next_st.scan_dv = 1'b0;
        end
        if (ev.single_valid) begin
            next_st.single_dv = 1'b1;
        end
        if (ev.scan_valid) begin
            next_st.scan_dv = 1'b1;
        end

        next_st.phase = PH_IDLE;
        next_st.rdata = '0;
        if (take) begin
            next_st.addr = ahb_i.haddr[11:0];
            if (ahb_i.hwrite) begin
                next_st.phase = PH_WRITE;
            end else begin
                next_st.phase = PH_READ;
                if (is_reg(ahb_i.haddr[11:0], OFS_FLAGS)) begin
                    next_st.rdata = next_st.flags;
                end else if (is_reg(ahb_i.haddr[11:0], OFS_IRQ_MASK)) begin
                    next_st.rdata = next_st.mask;
                end else if (is_reg(ahb_i.haddr[11:0], OFS_STATE)) begin
                    next_st.rdata = {30'h0000_0000, next_st.scan_dv, next_st.single_dv};
                end else if (is_reg(ahb_i.haddr[11:0], OFS_SINGLE_RES)) begin
                    next_st.rdmux     = 1'b1;
                    next_st.rd_single = 1'b1;
                end else if (is_reg(ahb_i.haddr[11:0], OFS_SCAN_RES)) begin
                    next_st.rdmux   = 1'b1;
                    next_st.rd_scan = 1'b1;
                end
            end
        end

        next_st.irq = |(next_st.flags & next_st.mask);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st       <= '0;
            st.phase <= PH_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // The result store registers its read word, so the mux reads it in the data phase.
    assign ahb_o.hrdata    = st.rdmux ? res_data : st.rdata;
    assign ahb_o.hreadyout = 1'b1;
    assign ahb_o.hresp     = 1'b0;
    assign irq_o           = st.irq;
    assign single_valid_o  = st.single_dv;
    assign scan_valid_o    = st.scan_dv;

    scan_ovf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_SET) && ahb_i.hwdata[9]
        |=> st.flags[9])
        else $error("Scan overflow flag not set by write.");
    single_ovf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_SET) && ahb_i.hwdata[8]
        |=> st.flags[8])
        else $error("Single overflow flag not set by write.");
    scan_done_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_SET) && ahb_i.hwdata[1]
        |=> st.flags[1])
        else $error("Scan complete flag not set by write.");
    single_done_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_SET) && ahb_i.hwdata[0]
        |=> st.flags[0])
        else $error("Single complete flag not set by write.");
    scan_ovf_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_CLEAR) && ahb_i.hwdata[9]
        && !ev.scan_ovf |=> !st.flags[9])
        else $error("Scan overflow flag not cleared.");
    single_ovf_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_CLEAR) && ahb_i.hwdata[8]
        && !ev.single_ovf |=> !st.flags[8])
        else $error("Single overflow flag not cleared.");
    scan_done_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_CLEAR) && ahb_i.hwdata[1]
        && !ev.scan_valid |=> !st.flags[1])
        else $error("Scan complete flag not cleared.");
    single_done_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_CLEAR) && ahb_i.hwdata[0]
        && !ev.single_valid |=> !st.flags[0])
        else $error("Single complete flag not cleared.");
    single_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take && !ahb_i.hwrite && is_reg(ahb_i.haddr[11:0], OFS_SINGLE_RES) && !res_wr
        |=> ahb_o.hrdata == $past(u_store.mem[0]))
        else $error("Single result read returned wrong word.");
    scan_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take && !ahb_i.hwrite && is_reg(ahb_i.haddr[11:0], OFS_SCAN_RES) && !res_wr
        |=> ahb_o.hrdata == $past(u_store.mem[1]))
        else $error("Scan result read returned wrong word.");
    single_dv_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.rd_single && !ev.single_valid |=> !single_valid_o)
        else $error("Single valid not cleared by read.");
    scan_dv_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.rd_scan && !ev.scan_valid |=> !scan_valid_o)
        else $error("Scan valid not cleared by read.");
    flag_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.flags & ~FLAG_MASK) == 32'h0000_0000)
        else $error("Reserved flag bit set.");
    flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && ahb_i.hwdata[9:8] == 2'h0 && !ev.scan_ovf && !ev.single_ovf
        |=> st.flags[9:8] == $past(st.flags[9:8]))
        else $error("Flag changed by write of zero.");
    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == |(st.flags & st.mask))
        else $error("Interrupt does not follow flags and mask.");

    // Converter events land in the flags and valid bits one cycle after capture.
    single_done_ev_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev.single_valid
        |=> st.flags[BIT_SINGLE_DONE])
        else $error("Single complete event did not set its flag.");
    scan_done_ev_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev.scan_valid
        |=> st.flags[BIT_SCAN_DONE])
        else $error("Scan complete event did not set its flag.");
    single_ovf_ev_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev.single_ovf
        |=> st.flags[BIT_SINGLE_OVF])
        else $error("Single overflow event did not set its flag.");
    scan_ovf_ev_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev.scan_ovf
        |=> st.flags[BIT_SCAN_OVF])
        else $error("Scan overflow event did not set its flag.");
    single_dv_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev.single_valid
        |=> single_valid_o)
        else $error("Single valid not raised by a new result.");
    scan_dv_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev.scan_valid
        |=> scan_valid_o)
        else $error("Scan valid not raised by a new result.");
    single_dv_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ev.single_valid && !st.rd_single
        |=> single_valid_o == $past(single_valid_o))
        else $error("Single valid changed with no result and no read.");
    scan_dv_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ev.scan_valid && !st.rd_scan
        |=> scan_valid_o == $past(scan_valid_o))
        else $error("Scan valid changed with no result and no read.");

    // A stored word changes only when a result of its own kind arrives.
    single_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev.single_valid && !ev.scan_valid
        |=> u_store.mem[0] == $past(ev.single_data))
        else $error("Single result not stored.");
    scan_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ev.scan_valid
        |=> u_store.mem[1] == $past(ev.scan_data))
        else $error("Scan result not stored.");
    single_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(ev.single_valid && !ev.scan_valid)
        |=> u_store.mem[0] == $past(u_store.mem[0]))
        else $error("Single result changed with no new result.");
    scan_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ev.scan_valid
        |=> u_store.mem[1] == $past(u_store.mem[1]))
        else $error("Scan result changed with no new result.");

    // Zero writes and writes to the flag register itself must not move a flag.
    done_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && ahb_i.hwdata[1:0] == 2'h0
        && !ev.single_valid && !ev.scan_valid
        |=> st.flags[1:0] == $past(st.flags[1:0]))
        else $error("Complete flag changed by write of zero.");
    flags_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAGS)
        && !ev.single_valid && !ev.scan_valid && !ev.single_ovf && !ev.scan_ovf
        |=> st.flags == $past(st.flags))
        else $error("Flag register changed by a write to it.");
    single_done_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !st.flags[0] && !ev.single_valid
        && !(st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_SET) && ahb_i.hwdata[0])
        |=> !st.flags[0])
        else $error("Single complete flag rose with no cause.");
    scan_done_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !st.flags[1] && !ev.scan_valid
        && !(st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_SET) && ahb_i.hwdata[1])
        |=> !st.flags[1])
        else $error("Scan complete flag rose with no cause.");

    // The mask is software state only; converter events never touch it.
    mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_IRQ_MASK)
        |=> st.mask == ($past(ahb_i.hwdata) & FLAG_MASK))
        else $error("Mask write did not land.");
    mask_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(st.phase == PH_WRITE && is_reg(st.addr, OFS_IRQ_MASK))
        |=> st.mask == $past(st.mask))
        else $error("Mask changed without a mask write.");

    // Outside a read data phase the bus sees zero, so stale results never leak out.
    rdata_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.phase != PH_READ
        |-> ahb_o.hrdata == 32'h0000_0000)
        else $error("Read data driven outside a read.");
    flags_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take && !ahb_i.hwrite && is_reg(ahb_i.haddr[11:0], OFS_FLAGS)
        |=> ahb_o.hrdata == st.flags)
        else $error("Flag read returned wrong word.");
    state_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take && !ahb_i.hwrite && is_reg(ahb_i.haddr[11:0], OFS_STATE)
        |=> ahb_o.hrdata == {30'h0000_0000, scan_valid_o, single_valid_o})
        else $error("State read returned wrong word.");
    wo_read_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take && !ahb_i.hwrite
        && (is_reg(ahb_i.haddr[11:0], OFS_FLAG_SET)
        || is_reg(ahb_i.haddr[11:0], OFS_FLAG_CLEAR))
        |=> ahb_o.hrdata == 32'h0000_0000)
        else $error("Set or clear register read as nonzero.");

    set_write_c: cover property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_SET));
    clear_write_c: cover property (@(posedge clk_i) disable iff (rst_i)
        st.phase == PH_WRITE && is_reg(st.addr, OFS_FLAG_CLEAR));
    single_read_c: cover property (@(posedge clk_i) disable iff (rst_i) st.rd_single);
    scan_read_c: cover property (@(posedge clk_i) disable iff (rst_i) st.rd_scan);
    irq_rise_c: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_o));
endmodule

// File: src/afr_result_store.sv
// Two-word result memory whose read data come out of a register.
`timescale 1ns/1ps
module afr_result_store
    import afr_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wr_en_i,
    input  wire logic             wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic             rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem [2];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem[0]    <= '0;
            mem[1]    <= '0;
            rd_data_o <= '0;
        end else begin
            if (wr_en_i) begin
                mem[wr_addr_i] <= wr_data_i;
            end
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule

// File: test/tb.sv
// Self-checking testbench for the flag and result register slice.
`timescale 1ns/1ps
module tb;
    import afr_pkg::*;

    logic         clk_i;
    logic         rst_i;
    afr_ahb_req_t mst;
    afr_ahb_req_t ahb_req;
    afr_ahb_rsp_t rsp;
    afr_conv_t    conv;
    logic         irq_o;
    logic         single_valid_o;
    logic         scan_valid_o;
    logic [31:0]  rd_word;
    logic         rd_resp;
    int           error_cnt;
    int           n_checks;
    int           bits [4] = '{0, 1, 8, 9};

    afr_regs dut (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .ahb_i          (ahb_req),
        .ahb_o          (rsp),
        .conv_i         (conv),
        .irq_o          (irq_o),
        .single_valid_o (single_valid_o),
        .scan_valid_o   (scan_valid_o)
    );

    initial clk_i = 1'b0;
    always #2 clk_i = ~clk_i;

    // The one slave's ready is the bus ready.
    always_comb begin
        ahb_req = mst;
        ahb_req.hready = rsp.hreadyout;
    end

    // Read data are captured with the edge that ends the data phase, avoiding a race.
    always @(posedge clk_i) begin
        rd_word <= rsp.hrdata;
        rd_resp <= rsp.hresp;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk_i);
        while (rsp.hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 50) begin
            error_cnt++;
            $display("wrong value hready expected 1 seen stuck");
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        mst.hsel   <= 1'b1;
        mst.haddr  <= {20'h00000, a};
        mst.htrans <= HTRANS_NSEQ;
        mst.hwrite <= wr;
        mst.hsize  <= HSIZE_WORD;
        wait_ready();
        mst.hsel   <= 1'b0;
        mst.htrans <= 2'h0;
        mst.hwdata <= wr ? d : 32'h0000_0000;
        wait_ready();
        #1;
        q = rd_word;
        chk("hresp", 32'h0, {31'h0, rd_resp});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(name, exp, q);
    endtask

    task automatic t_reset();
        rd_chk("flags", OFS_FLAGS, RESET_WORD);
        rd_chk("single result", OFS_SINGLE_RES, RESET_WORD);
        rd_chk("scan result", OFS_SCAN_RES, RESET_WORD);
        chk("irq", 32'h0, {31'h0, irq_o});
    endtask

    // Each flag is set, masked, unmasked and cleared; zero writes must not disturb it.
    task automatic t_set_clear();
        logic [31:0] f;
        foreach (bits[i]) begin
            f = 32'h1 << bits[i];
            wr(OFS_FLAG_SET, f);
            rd_chk("flag set", OFS_FLAGS, f);
            chk("irq masked", 32'h0, {31'h0, irq_o});
            wr(OFS_IRQ_MASK, f);
            chk("irq unmasked", 32'h1, {31'h0, irq_o});
            wr(OFS_FLAG_SET, 32'h0000_0000);
            wr(OFS_FLAG_CLEAR, 32'h0000_0000);
            rd_chk("flag kept", OFS_FLAGS, f);
            wr(OFS_FLAG_CLEAR, f);
            rd_chk("flag cleared", OFS_FLAGS, 32'h0);
            chk("irq after clear", 32'h0, {31'h0, irq_o});
            wr(OFS_IRQ_MASK, 32'h0000_0000);
        end
    endtask

    task automatic t_result(input logic scan, input logic [31:0] d);
        logic [11:0] a;
        a = scan ? OFS_SCAN_RES : OFS_SINGLE_RES;
        @(posedge clk_i);
        conv.scan_valid   <= scan;
        conv.single_valid <= !scan;
        conv.scan_data    <= d;
        conv.single_data  <= d;
        @(posedge clk_i);
        conv <= '0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("valid raised", 32'h1, {31'h0, scan ? scan_valid_o : single_valid_o});
        rd_chk("state", OFS_STATE, scan ? 32'h2 : 32'h1);
        rd_chk("flags event", OFS_FLAGS, scan ? 32'h2 : 32'h1);
        rd_chk("result", a, d);
        @(posedge clk_i);
        #1;
        chk("valid after read", 32'h0, {31'h0, scan ? scan_valid_o : single_valid_o});
        rd_chk("result kept", a, d);
        wr(OFS_FLAG_CLEAR, 32'h0000_0303);
    endtask

    // Overflow events, writes to read-only places and an unmapped address.
    task automatic t_misc();
        @(posedge clk_i);
        conv.single_ovf <= 1'b1;
        conv.scan_ovf   <= 1'b1;
        @(posedge clk_i);
        conv <= '0;
        rd_chk("overflow flags", OFS_FLAGS, 32'h0000_0300);
        wr(OFS_FLAG_CLEAR, 32'h0000_0100);
        rd_chk("one overflow left", OFS_FLAGS, 32'h0000_0200);
        wr(OFS_FLAGS, 32'h0000_0303);
        rd_chk("flags read only", OFS_FLAGS, 32'h0000_0200);
        wr(OFS_FLAG_CLEAR, 32'h0000_0200);
        wr(OFS_SCAN_RES, 32'hFFFF_FFFF);
        rd_chk("scan read only", OFS_SCAN_RES, 32'h5A0F_C3E1);
        rd_chk("unmapped", 12'h100, 32'h0000_0000);
        rd_chk("set reads zero", OFS_FLAG_SET, 32'h0000_0000);
        rd_chk("clear reads zero", OFS_FLAG_CLEAR, 32'h0000_0000);
        rd_chk("flags end", OFS_FLAGS, 32'h0000_0000);
    endtask

    initial begin
        mst       = '0;
        conv      = '0;
        rst_i     = 1'b1;
        error_cnt = 0;
        n_checks  = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_set_clear();
        t_result(1'b0, 32'hA5C3_1E0F);
        t_result(1'b1, 32'h5A0F_C3E1);
        t_misc();
        give_verdict();
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end
endmodule
